// ==== sim/incbit_unit_monitor.sv ====
/*
  Checker for incbit_unit: byte and state counts, carry results, timing.
  Assumes it is bound to incbit_unit and sees only that module's ports.
*/
`timescale 1ns/1ps
module incbit_unit_monitor #(
  parameter int unsigned WAIT_STATES_W = incbit_pkg::WAIT_W
) (
  // clock and reset
  input wire logic                     clk,
  input wire logic                     reset_n,
  // configuration and request
  input wire logic                     source_mode_strap,
  input wire logic [WAIT_STATES_W-1:0] ext_wait_states,
  input wire logic                     req_valid,
  input wire incbit_pkg::req_t         req,
  input wire logic                     carry_in,
  // answer
  input wire logic                     busy,
  input wire logic                     done,
  input wire incbit_pkg::res_t         res
);
  // --------------------------------------------------
  // request capture
  // --------------------------------------------------
  logic                     take;
  logic                     rel_q;
  logic                     mode_q;
  logic                     cin_q;
  logic [5:0]               cnt_q;
  logic [WAIT_STATES_W-1:0] n_q;
  incbit_pkg::req_t         rq_q;

  assign take = req_valid && !busy;

  // inputs may move after the take, so keep our own copy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rel_q  <= 1'b0;
      mode_q <= 1'b0;
      cin_q  <= 1'b0;
      cnt_q  <= 6'h00;
      n_q    <= '0;
      rq_q   <= '0;
    end else begin
      rel_q <= 1'b1;
      if (!rel_q) mode_q <= source_mode_strap;
      if (take) begin
        // counts the busy edges up to and including the one raising done
        cnt_q <= 6'h00;
        rq_q  <= req;
        cin_q <= carry_in;
        n_q   <= ext_wait_states;
      end else if (busy) cnt_q <= cnt_q + 6'h01;
    end
  end

  // --------------------------------------------------
  // assertions
  // --------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_done_pulse: assert property (done && !take |=> !done)
    else $error("done held past one cycle");
  a_done_count: assert property (
    done |-> cnt_q == ((res.states == 6'h00) ? 6'h01 : res.states))
    else $error("done not at the stated count");
  a_first_answer: assert property (take |=> ##1 (done == (res.states <= 6'h01)))
    else $error("short op answer late");
  a_res_hold: assert property (!take |=> $stable(res))
    else $error("result moved without a request");
  a_short_count: assert property (
    done && rq_q.op inside {[incbit_pkg::OP_ADD_BYTE_SHORT:incbit_pkg::OP_SUB_WORD_SHORT]}
    |-> res.length == (mode_q ? 3'h2 : 3'h3) && res.states == (mode_q ? 6'h01 : 6'h02))
    else $error("short add counts wrong");
  a_dword_sub: assert property (
    done && rq_q.op == incbit_pkg::OP_SUB_DWORD_SHORT |-> res.states == (mode_q ? 6'h04 : 6'h05))
    else $error("dword subtract states wrong");
  a_direct_extra: assert property (
    done && rq_q.op inside {incbit_pkg::OP_INC_DIRECT, incbit_pkg::OP_DOWN_DIRECT}
    |-> res.states == 6'h02 + (rq_q.region == incbit_pkg::REG_IO_PORT ? 6'h02 :
                               rq_q.region == incbit_pkg::REG_PERIPH ? 6'h03 : 6'h00))
    else $error("direct step states wrong");
  a_and_carry: assert property (
    done && rq_q.op == incbit_pkg::OP_AND_BIT |-> res.carry_flag == (cin_q & rq_q.bit_in))
    else $error("and carry wrong");
  a_or_ncarry: assert property (
    done && rq_q.op == incbit_pkg::OP_OR_NBIT |-> res.carry_flag == (cin_q | !rq_q.bit_in))
    else $error("or complement carry wrong");
  a_ext_byte: assert property (
    done && rq_q.op == incbit_pkg::OP_ST_BYTE_DISP16 && rq_q.region == incbit_pkg::REG_EXTERNAL
    |-> res.states == (mode_q ? 6'h05 : 6'h06) + 6'(n_q) + 6'h02)
    else $error("external byte states wrong");
  a_byte_wrap: assert property (
    done && rq_q.op == incbit_pkg::OP_ADD_BYTE_SHORT
    |-> res.result == {24'h000000, rq_q.operand[7:0] + {5'h00, rq_q.short_val}})
    else $error("byte add did not wrap");

  // main scenarios reached
  c_external: cover property (done && rq_q.region == incbit_pkg::REG_EXTERNAL);
  c_source: cover property (done && mode_q);
  c_ext_bit: cover property (done && rq_q.ext_bit);
endmodule

bind incbit_unit incbit_unit_monitor #(.WAIT_STATES_W(WAIT_STATES_W)) incbit_unit_monitor_inst (
  .clk(clk), .reset_n(reset_n), .source_mode_strap(source_mode_strap),
  .ext_wait_states(ext_wait_states), .req_valid(req_valid), .req(req),
  .carry_in(carry_in), .busy(busy), .done(done), .res(res));

// ==== sim/incbit_unit_tb_top.sv ====
/*
  Self-checking bench for incbit_unit, both encoding modes.
  Assumes the package and unit are compiled first; no far-side model.
*/
`timescale 1ns/1ps
module incbit_unit_tb_top;
  // --------------------------------------------------
  // signals
  // --------------------------------------------------
  logic                               clk;
  logic                               reset_n;
  logic                               source_mode_strap;
  logic [incbit_pkg::WAIT_W-1:0]      ext_wait_states;
  logic                               req_valid;
  incbit_pkg::req_t                   req;
  logic                               carry_in;
  logic                               busy;
  logic                               done;
  incbit_pkg::res_t                   res;
  incbit_pkg::res_t                   got;
  logic [5:0]                         lat;
  logic                               mode;
  int                                 n_fail;
  int                                 n_tests;
  int                                 cycles;

  incbit_unit #(.WAIT_STATES_W(incbit_pkg::WAIT_W)) incbit_unit_inst (
    .clk(clk), .reset_n(reset_n), .source_mode_strap(source_mode_strap),
    .ext_wait_states(ext_wait_states), .req_valid(req_valid), .req(req),
    .carry_in(carry_in), .busy(busy), .done(done), .res(res));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // a hung handshake ends the run instead of stalling it
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end

  // --------------------------------------------------
  // compare and drive helpers
  // --------------------------------------------------
  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_t(input logic [2:0] el, input logic [5:0] es);
    chk_w({29'h0, got.length}, {29'h0, el});
    chk_w({26'h0, got.states}, {26'h0, es});
    chk_w({26'h0, lat}, {26'h0, es});  // answer must come after exactly that many cycles
  endtask

  task automatic conclude();
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // strap is only looked at just after release
  task automatic do_reset(input logic m);
    @(posedge clk);
    reset_n <= 1'b0;
    source_mode_strap <= m;
    mode = m;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk_w({31'h0, busy}, 32'h0);
  endtask

  task automatic run_op(input int op, input int rg, input logic ext, input logic [2:0] sv,
                        input logic [31:0] opnd, input logic bi, input logic cin);
    int k;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{incbit_pkg::op_t'(op), incbit_pkg::region_t'(rg), ext, sv, opnd, bi};
    carry_in <= cin;
    @(posedge clk);
    req_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      #1;
    end while (done !== 1'b1 && k < 63);
    lat = 6'(k);
    got = res;
  endtask

  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  // byte, word, dword short add/sub with wrap at each width
  task automatic t_short();
    logic [31:0] w;
    logic [31:0] o;
    logic [2:0]  sv;
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 3; j++) begin
        sv = 3'h1 << j;
        o = (i % 2 == 0) ? 32'hFFFF_FFFE : 32'h0001_0001;
        w = (i < 2) ? 32'h0000_00FF : (i < 4) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
        run_op(i, 0, 1'b0, sv, o, 1'b0, 1'b0);
        chk_w(got.result, ((i % 2 == 0) ? o + sv : o - sv) & w);
        chk_t(mode ? 3'h2 : 3'h3, (i < 4) ? (mode ? 6'h01 : 6'h02) :
              (i == 4) ? (mode ? 6'h03 : 6'h04) : (mode ? 6'h04 : 6'h05));
      end
    end
  endtask

  // direct step by one in on-chip, port and peripheral regions
  task automatic t_direct();
    for (int i = 6; i < 8; i++) begin
      for (int r = 0; r < 3; r++) begin
        run_op(i, r, 1'b0, 3'h1, (i == 6) ? 32'hFF : 32'h00, 1'b0, 1'b0);
        chk_w(got.result, (i == 6) ? 32'h00 : 32'hFF);
        chk_t(3'h2, 6'h02 + ((r == 1) ? 6'h02 : (r == 2) ? 6'h03 : 6'h00));
      end
    end
  endtask

  // bit reads into carry, every value pair, both address kinds
  task automatic t_bit_read();
    logic e;
    for (int i = 8; i < 13; i++) begin
      for (int v = 0; v < 32; v++) begin
        run_op(i, v % 3, v[2], 3'h1, 32'h0, v[3], v[4]);
        e = (i == 8) ? v[4] & v[3] : (i == 9) ? v[4] & !v[3] :
            (i == 10) ? v[4] | v[3] : (i == 11) ? v[4] | !v[3] : v[3];
        chk_w({31'h0, got.carry_flag}, {31'h0, e});
        chk_t(v[2] ? (mode ? 3'h3 : 3'h4) : 3'h2,
              (v[2] ? (mode ? 6'h02 : 6'h03) : 6'h01) + 6'(v % 3));
      end
    end
  endtask

  // carry written to a bit
  task automatic t_bit_write();
    for (int v = 0; v < 4; v++) begin
      run_op(13, 0, v[0], 3'h1, 32'h0, !v[1], v[1]);
      chk_w({31'h0, got.bit_out}, {31'h0, v[1]});
      chk_t(v[0] ? (mode ? 3'h3 : 3'h4) : 3'h2,
            v[0] ? (mode ? 6'h03 : 6'h04) : 6'h02);
    end
  endtask

  // displacement transfers, on chip and external with two wait settings
  task automatic t_disp();
    logic [5:0] b;
    logic [5:0] x;
    for (int n = 0; n < 2; n++) begin
      @(posedge clk);
      ext_wait_states <= n[0] ? 4'hF : 4'h0;
      for (int i = 14; i < 17; i++) begin
        for (int r = 0; r < 4; r += 3) begin
          run_op(i, r, 1'b0, 3'h1, 32'h1234_5678, 1'b0, 1'b0);
          b = (mode ? 6'h05 : 6'h06) + 6'(i - 14);
          x = (r == 0) ? 6'h00 : (i == 14) ? 6'(n * 15) + 6'h02 : 6'h02 * (6'(n * 15) + 6'h01);
          chk_t(mode ? 3'h4 : 3'h5, b + x);
        end
      end
    end
  endtask

  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial begin
    reset_n = 1'b0;
    source_mode_strap = 1'b0;
    ext_wait_states = '0;
    req_valid = 1'b0;
    req = '0;
    carry_in = 1'b0;
    n_fail = 0;
    n_tests = 0;
    cycles = 0;
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0]);
      t_short();
      t_direct();
      t_bit_read();
      t_bit_write();
      t_disp();
    end
    conclude();
  end
endmodule

// ==== verilog/incbit_pkg.sv ====
/*
  Shared constants and types for the increment and bit-operation unit:
  instruction forms, operand region kinds, byte and state counts.
  Assumes the including core provides decoded forms and operand values.
*/
package incbit_pkg;

  // ------------------------------------------------------------
  // instruction forms handled by the unit
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_ADD_BYTE_SHORT,    // add small constant to byte_reg
    OP_SUB_BYTE_SHORT,    // subtract_small_op on byte_reg
    OP_ADD_WORD_SHORT,
    OP_SUB_WORD_SHORT,
    OP_ADD_DWORD_SHORT,
    OP_SUB_DWORD_SHORT,
    OP_INC_DIRECT,        // direct_byte_addr plus one
    OP_DOWN_DIRECT,       // direct_byte_addr minus one
    OP_AND_BIT,           // and_logic_op into carry_flag
    OP_AND_NBIT,
    OP_OR_BIT,            // or_logic_op into carry_flag
    OP_OR_NBIT,
    OP_BIT_TO_CARRY,      // transfer_op bit into carry
    OP_CARRY_TO_BIT,      // transfer_op carry into bit
    OP_ST_BYTE_DISP16,    // byte_reg to word_reg pointer plus displacement
    OP_ST_WORD_DISP16,    // word_reg to word_reg pointer plus displacement
    OP_LD_WORD_DISP24     // dword_reg pointer plus displacement to word_reg
  } op_t;

  // operand region seen by the operand address
  typedef enum logic [1:0] {
    REG_ONCHIP,
    REG_IO_PORT,
    REG_PERIPH,
    REG_EXTERNAL
  } region_t;

  // ------------------------------------------------------------
  // request and result carriers
  // ------------------------------------------------------------
  typedef struct packed {
    op_t         op;
    region_t     region;
    logic        ext_bit;     // extended bit address, else legacy_bit_addr
    logic [2:0]  short_val;   // 1, 2 or 4
    logic [31:0] operand;     // destination operand value
    logic        bit_in;      // source bit value
  } req_t;

  typedef struct packed {
    logic [31:0] result;
    logic        carry_flag;
    logic        bit_out;
    logic [2:0]  length;      // instruction bytes
    logic [5:0]  states;      // total states spent
  } res_t;

  // ------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned WAIT_W   = 4;
  localparam logic [5:0]  STATE_W0 = 6'h00;

  // ------------------------------------------------------------
  // byte counts, binary mode then source mode
  // ------------------------------------------------------------
  localparam logic [2:0] LEN_SHORT_BIN   = 3'h3;
  localparam logic [2:0] LEN_SHORT_SRC   = 3'h2;
  localparam logic [2:0] LEN_DIRECT      = 3'h2;
  localparam logic [2:0] LEN_BIT_LEG     = 3'h2;
  localparam logic [2:0] LEN_BIT_EXT_BIN = 3'h4;
  localparam logic [2:0] LEN_BIT_EXT_SRC = 3'h3;
  localparam logic [2:0] LEN_DISP_BIN    = 3'h5;
  localparam logic [2:0] LEN_DISP_SRC    = 3'h4;

  // ------------------------------------------------------------
  // base state counts, binary mode then source mode
  // ------------------------------------------------------------
  localparam logic [5:0] ST_SHORT_BIN     = 6'h02;
  localparam logic [5:0] ST_SHORT_SRC     = 6'h01;
  localparam logic [5:0] ST_ADD_DW_BIN    = 6'h04;
  localparam logic [5:0] ST_ADD_DW_SRC    = 6'h03;
  localparam logic [5:0] ST_SUB_DW_BIN    = 6'h05;
  localparam logic [5:0] ST_SUB_DW_SRC    = 6'h04;
  localparam logic [5:0] ST_DIRECT        = 6'h02;
  localparam logic [5:0] ST_RDBIT_LEG     = 6'h01;
  localparam logic [5:0] ST_RDBIT_EXT_BIN = 6'h03;
  localparam logic [5:0] ST_RDBIT_EXT_SRC = 6'h02;
  localparam logic [5:0] ST_WRBIT_LEG     = 6'h02;
  localparam logic [5:0] ST_WRBIT_EXT_BIN = 6'h04;
  localparam logic [5:0] ST_WRBIT_EXT_SRC = 6'h03;
  localparam logic [5:0] ST_ST_BYTE_BIN   = 6'h06;
  localparam logic [5:0] ST_ST_BYTE_SRC   = 6'h05;
  localparam logic [5:0] ST_ST_WORD_BIN   = 6'h07;
  localparam logic [5:0] ST_ST_WORD_SRC   = 6'h06;
  localparam logic [5:0] ST_LD_WORD_BIN   = 6'h08;
  localparam logic [5:0] ST_LD_WORD_SRC   = 6'h07;

  // ------------------------------------------------------------
  // extra states for slow operand regions
  // ------------------------------------------------------------
  localparam logic [5:0] XT_DIR_IO      = 6'h02;
  localparam logic [5:0] XT_DIR_PERIPH  = 6'h03;
  localparam logic [5:0] XT_RBIT_IO     = 6'h01;
  localparam logic [5:0] XT_RBIT_PERIPH = 6'h02;
  localparam logic [5:0] XT_EXT_BYTE    = 6'h02;  // plus wait states
  localparam logic [5:0] XT_EXT_WORD    = 6'h01;  // plus wait, then doubled

endpackage

// ==== verilog/incbit_unit.sv ====
/*
  Increment, small add/subtract, carry bit logic and displacement
  transfer datapath. Computes result, carry, bit and the byte and state
  counts, then holds busy for the state count before raising done.
  Assumes one clock, requests only while idle, binary/source mode strap
  stable around reset release.
*/
// What this block does
// - byte_reg short add/sub: 3 bytes 2 states binary, 2 bytes 1 state source
// - word_reg short add/sub: 3 bytes 2 states binary, 2 bytes 1 state source
// - dword_reg add 4/3 states, subtract 5/4 states, binary/source
// - direct byte increment/decrement: 2 bytes, 2 states both modes
// - direct increment/decrement adds 2 states for port, 3 for peripheral
// - and bit into carry; 1 state legacy, 3 binary or 2 source extended
// - and complemented bit into carry; same counts as plain form
// - or bit or complement into carry; 1 legacy, 3 binary, 2 source
// - bit to carry: 2B/1 legacy; extended 4B/3 binary, 3B/2 source
// - carry to bit: 2 states legacy; extended 4 binary, 3 source
// - bit reads into carry add 1 state port, 2 peripheral
// - byte store via word pointer plus displacement: 5B/6 binary, 4B/5 source
// - word store via word pointer plus displacement: 7 binary, 6 source
// - word load via dword pointer: 5B/8 binary, 4B/7 source
// - external byte displacement transfer adds wait states plus 2
// - external word displacement transfer adds wait states plus 1, doubled
`timescale 1ns/1ps

module incbit_unit #(
  parameter int unsigned WAIT_STATES_W = incbit_pkg::WAIT_W
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // configuration
  input  wire logic                     source_mode_strap,
  input  wire logic [WAIT_STATES_W-1:0] ext_wait_states,
  // request
  input  wire logic                     req_valid,
  input  wire incbit_pkg::req_t         req,
  input  wire logic                     carry_in,
  // answer
  output logic                          busy,
  output logic                          done,
  output incbit_pkg::res_t              res
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {S_BOOT, S_IDLE, S_RUN} phase_t;

  typedef struct packed {
    phase_t           phase;
    logic             src_mode;
    logic [5:0]       count;
    logic             busy;
    logic             done;
    incbit_pkg::res_t res;
  } state_t;

  state_t state_q;
  state_t state_d;

  // ------------------------------------------------------------
  // operation datapath, combinational
  // ------------------------------------------------------------
  incbit_pkg::res_t calc;
  logic [31:0]      step;
  logic [5:0]       wait6;

  always_comb begin
    wait6 = 6'(ext_wait_states);
    step  = {29'h0, req.short_val};
    calc  = '0;
    calc.carry_flag = carry_in;
    calc.result     = req.operand;
    case (req.op)
      // short register forms
      incbit_pkg::OP_ADD_BYTE_SHORT, incbit_pkg::OP_SUB_BYTE_SHORT: begin
        calc.result = {24'h0, (req.op == incbit_pkg::OP_ADD_BYTE_SHORT) ?
                       8'(req.operand[7:0] + step[7:0]) :
                       8'(req.operand[7:0] - step[7:0])};
        calc.length = state_q.src_mode ? incbit_pkg::LEN_SHORT_SRC :
                                         incbit_pkg::LEN_SHORT_BIN;
        calc.states = state_q.src_mode ? incbit_pkg::ST_SHORT_SRC :
                                         incbit_pkg::ST_SHORT_BIN;
      end
      incbit_pkg::OP_ADD_WORD_SHORT, incbit_pkg::OP_SUB_WORD_SHORT: begin
        calc.result = {16'h0, (req.op == incbit_pkg::OP_ADD_WORD_SHORT) ?
                       16'(req.operand[15:0] + step[15:0]) :
                       16'(req.operand[15:0] - step[15:0])};
        calc.length = state_q.src_mode ? incbit_pkg::LEN_SHORT_SRC :
                                         incbit_pkg::LEN_SHORT_BIN;
        calc.states = state_q.src_mode ? incbit_pkg::ST_SHORT_SRC :
                                         incbit_pkg::ST_SHORT_BIN;
      end
      incbit_pkg::OP_ADD_DWORD_SHORT: begin
        calc.result = req.operand + step;
        calc.length = state_q.src_mode ? incbit_pkg::LEN_SHORT_SRC :
                                         incbit_pkg::LEN_SHORT_BIN;
        calc.states = state_q.src_mode ? incbit_pkg::ST_ADD_DW_SRC :
                                         incbit_pkg::ST_ADD_DW_BIN;
      end
      incbit_pkg::OP_SUB_DWORD_SHORT: begin
        calc.result = req.operand - step;
        calc.length = state_q.src_mode ? incbit_pkg::LEN_SHORT_SRC :
                                         incbit_pkg::LEN_SHORT_BIN;
        calc.states = state_q.src_mode ? incbit_pkg::ST_SUB_DW_SRC :
                                         incbit_pkg::ST_SUB_DW_BIN;
      end
      // direct byte increment and decrement
      incbit_pkg::OP_INC_DIRECT, incbit_pkg::OP_DOWN_DIRECT: begin
        calc.result = {24'h0, (req.op == incbit_pkg::OP_INC_DIRECT) ?
                       8'(req.operand[7:0] + 8'h01) :
                       8'(req.operand[7:0] - 8'h01)};
        calc.length = incbit_pkg::LEN_DIRECT;
        calc.states = incbit_pkg::ST_DIRECT;
        if (req.region == incbit_pkg::REG_IO_PORT) begin
          calc.states = incbit_pkg::ST_DIRECT + incbit_pkg::XT_DIR_IO;
        end else if (req.region == incbit_pkg::REG_PERIPH) begin
          calc.states = incbit_pkg::ST_DIRECT + incbit_pkg::XT_DIR_PERIPH;
        end
      end
      // bit reads into carry
      incbit_pkg::OP_AND_BIT, incbit_pkg::OP_AND_NBIT, incbit_pkg::OP_OR_BIT,
      incbit_pkg::OP_OR_NBIT, incbit_pkg::OP_BIT_TO_CARRY: begin
        case (req.op)
          incbit_pkg::OP_AND_BIT:  calc.carry_flag = carry_in & req.bit_in;
          incbit_pkg::OP_AND_NBIT: calc.carry_flag = carry_in & ~req.bit_in;
          incbit_pkg::OP_OR_BIT:   calc.carry_flag = carry_in | req.bit_in;
          incbit_pkg::OP_OR_NBIT:  calc.carry_flag = carry_in | ~req.bit_in;
          default:                 calc.carry_flag = req.bit_in;
        endcase
        if (!req.ext_bit) begin
          calc.length = incbit_pkg::LEN_BIT_LEG;
          calc.states = incbit_pkg::ST_RDBIT_LEG;
        end else begin
          calc.length = state_q.src_mode ? incbit_pkg::LEN_BIT_EXT_SRC :
                                           incbit_pkg::LEN_BIT_EXT_BIN;
          calc.states = state_q.src_mode ? incbit_pkg::ST_RDBIT_EXT_SRC :
                                           incbit_pkg::ST_RDBIT_EXT_BIN;
        end
        if (req.region == incbit_pkg::REG_IO_PORT) begin
          calc.states = calc.states + incbit_pkg::XT_RBIT_IO;
        end else if (req.region == incbit_pkg::REG_PERIPH) begin
          calc.states = calc.states + incbit_pkg::XT_RBIT_PERIPH;
        end
      end
      // carry written out to a bit
      incbit_pkg::OP_CARRY_TO_BIT: begin
        calc.bit_out = carry_in;
        if (!req.ext_bit) begin
          calc.length = incbit_pkg::LEN_BIT_LEG;
          calc.states = incbit_pkg::ST_WRBIT_LEG;
        end else begin
          calc.length = state_q.src_mode ? incbit_pkg::LEN_BIT_EXT_SRC :
                                           incbit_pkg::LEN_BIT_EXT_BIN;
          calc.states = state_q.src_mode ? incbit_pkg::ST_WRBIT_EXT_SRC :
                                           incbit_pkg::ST_WRBIT_EXT_BIN;
        end
      end
      // displacement transfers; data passes straight through
      incbit_pkg::OP_ST_BYTE_DISP16: begin
        calc.result = {24'h0, req.operand[7:0]};
        calc.length = state_q.src_mode ? incbit_pkg::LEN_DISP_SRC :
                                         incbit_pkg::LEN_DISP_BIN;
        calc.states = state_q.src_mode ? incbit_pkg::ST_ST_BYTE_SRC :
                                         incbit_pkg::ST_ST_BYTE_BIN;
        if (req.region == incbit_pkg::REG_EXTERNAL) begin
          calc.states = calc.states + wait6 + incbit_pkg::XT_EXT_BYTE;
        end
      end
      incbit_pkg::OP_ST_WORD_DISP16, incbit_pkg::OP_LD_WORD_DISP24: begin
        calc.result = {16'h0, req.operand[15:0]};
        calc.length = state_q.src_mode ? incbit_pkg::LEN_DISP_SRC :
                                         incbit_pkg::LEN_DISP_BIN;
        if (req.op == incbit_pkg::OP_ST_WORD_DISP16) begin
          calc.states = state_q.src_mode ? incbit_pkg::ST_ST_WORD_SRC :
                                           incbit_pkg::ST_ST_WORD_BIN;
        end else begin
          calc.states = state_q.src_mode ? incbit_pkg::ST_LD_WORD_SRC :
                                           incbit_pkg::ST_LD_WORD_BIN;
        end
        if (req.region == incbit_pkg::REG_EXTERNAL) begin
          // word access is two byte cycles, each with its own waits
          calc.states = calc.states +
                        6'((wait6 + incbit_pkg::XT_EXT_WORD) << 1);
        end
      end
      default: begin
        calc = '0;
        calc.carry_flag = carry_in;
      end
    endcase
  end

  // ------------------------------------------------------------
  // sequencer: strap capture, then one state per clock
  // ------------------------------------------------------------
  always_comb begin
    state_d      = state_q;
    state_d.done = 1'b0;
    case (state_q.phase)
      S_BOOT: begin
        // strap sampled after release, never under the async reset
        state_d.src_mode = source_mode_strap;
        state_d.phase    = S_IDLE;
      end
      S_IDLE: begin
        // first idle cycle after boot still shows busy, so nothing is taken then
        state_d.busy = 1'b0;
        if (req_valid && !state_q.busy) begin
          state_d.res   = calc;
          state_d.count = calc.states;
          state_d.busy  = 1'b1;
          state_d.phase = S_RUN;
        end
      end
      S_RUN: begin
        // a count of zero (unknown op) ends after one state, same as a count of one
        if (state_q.count <= 6'h01) begin
          state_d.busy  = 1'b0;
          state_d.done  = 1'b1;
          state_d.count = incbit_pkg::STATE_W0;
          state_d.phase = S_IDLE;
        end else begin
          state_d.count = 6'(state_q.count - 6'h01);
        end
      end
      default: begin
        state_d.phase = S_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '{phase: S_BOOT, src_mode: 1'b0, count: incbit_pkg::STATE_W0,
                   busy: 1'b1, done: 1'b0, res: '0};
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from flops
  assign busy = state_q.busy;
  assign done = state_q.done;
  assign res  = state_q.res;

endmodule
